//--- include/reading_output_formatter_regs.vh
/*
 constants for the reading output formatter: formats, characters, overrange codes,
 memory and buffer sizes, resolution and overrange values in 64-bit real form.
 assumes a tool that folds $realtobits of a literal into a constant.
*/
`ifndef READING_OUTPUT_FORMATTER_REGS_VH
`define READING_OUTPUT_FORMATTER_REGS_VH

`define FMT_ASCII       2'h0
`define FMT_PACKED      2'h1
`define FMT_REAL        2'h2

`define CHR_HASH        8'h23
`define CHR_COMMA       8'h2C
`define CHR_MINUS       8'h2D
`define CHR_ZERO        8'h30
`define CHR_LF          8'h0A

`define CODE_OVR_POS    12'h7FF
`define CODE_OVR_NEG    12'h802
`define CODE_OVR_AMP    12'h800

`define MEM_DEPTH       9'h100
`define MEM_AW          8
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define PACKED_BYTES    4'h2
`define REAL_BYTES      4'h8

`define REAL_OVR_POS    $realtobits(9.9e37)
`define REAL_OVR_NEG    $realtobits(-9.9e37)
`define RES_R0          $realtobits(0.00005)
`define RES_R1          $realtobits(0.0001)
`define RES_R2          $realtobits(0.00025)
`define RES_R3          $realtobits(0.0005)
`define RES_R4          $realtobits(0.001)
`define RES_R5          $realtobits(0.0025)
`define RES_R6          $realtobits(0.005)
`define RES_R7          $realtobits(0.01)
`define RES_R8          $realtobits(0.025)
`define RES_R9          $realtobits(0.05)

`endif

//--- rtl/reading_output_formatter.v
/*
 reading output formatter: captures converter readings into memory, buffers them
 through a fifo, live or replayed from memory, and emits them as a byte stream in text, packed
 or real format with closing line feed plus end-or-identify and, in packed and real, a block header.
 assumes all inputs synchronous to ref_clk and a byte sink with valid/ready.
*/
`timescale 1ns/1ps
`include "reading_output_formatter_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module reading_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW    = `FIFO_AW
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   localparam [AW:0] FULL = DEPTH[AW:0];
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW:0]      wp_reg;
   reg  [AW:0]      rp_reg;
   wire [AW:0]      fill = wp_reg - rp_reg;

   assign in_ready  = (fill != FULL);
   assign out_valid = (fill != {(AW+1){1'b0}});
   assign out_data  = mem[rp_reg[AW-1:0]];

   always @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wp_reg[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg <= {(AW+1){1'b0}};
         rp_reg <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && in_ready) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (out_valid && out_ready) begin
            rp_reg <= rp_reg + 1'b1;
         end
      end
   end
endmodule // reading_fifo

////////////////////////////////////////////////////////////////////////////////
module reading_output_formatter (
   input  wire        ref_clk,
   input  wire        rstn,
   input  wire        acquisition_launch,
   input  wire [8:0]  reading_count,
   input  wire [1:0]  format_select,
   input  wire [3:0]  channel_label,
   input  wire        label_assigned,
   input  wire        vme_source_select,
   input  wire        local_bus_source_select,
   input  wire        local_bus_route,
   input  wire [3:0]  range_select,
   input  wire        adc_valid,
   output wire        adc_ready,
   input  wire [11:0] adc_code,
   input  wire        questionable_clear,
   output wire        questionable_amp_over,
   output wire        out_valid,
   input  wire        out_ready,
   output wire [7:0]  out_data,
   output wire        out_eoi,
   output wire        busy
);
   localparam [6:0] S_IDLE  = 7'h01;
   localparam [6:0] S_HASH  = 7'h02;
   localparam [6:0] S_NDIG  = 7'h04;
   localparam [6:0] S_FETCH = 7'h08;
   localparam [6:0] S_DATA  = 7'h10;
   localparam [6:0] S_LF    = 7'h20;
   localparam [6:0] S_SPARE = 7'h40;

   // decimal text of v: {char count, four chars left aligned}
   function [35:0] dec_text;
      input [11:0] v;
      reg   [31:0] ch;
      reg   [3:0]  n;
      reg   [11:0] d3;
      reg   [11:0] d2;
      reg   [11:0] d1;
      reg   [11:0] d0;
      begin
         // digits cut to a byte first; twelve-bit terms would spill past the concatenation
         d3 = v / 12'd1000 % 12'd10;
         d2 = v / 12'd100 % 12'd10;
         d1 = v / 12'd10 % 12'd10;
         d0 = v % 12'd10;
         ch = {`CHR_ZERO + d3[7:0], `CHR_ZERO + d2[7:0], `CHR_ZERO + d1[7:0], `CHR_ZERO + d0[7:0]};
         n  = (v >= 12'd1000) ? 4'h4 : (v >= 12'd100) ? 4'h3 : (v >= 12'd10) ? 4'h2 : 4'h1;
         ch = ch << (6'd8 * (6'd4 - {2'b0, n}));
         dec_text = {n, ch};
      end
   endfunction

   function [63:0] res_of;
      input [3:0] r;
      begin
         case (r)
            4'h0:    res_of = `RES_R0;
            4'h1:    res_of = `RES_R1;
            4'h2:    res_of = `RES_R2;
            4'h3:    res_of = `RES_R3;
            4'h4:    res_of = `RES_R4;
            4'h5:    res_of = `RES_R5;
            4'h6:    res_of = `RES_R6;
            4'h7:    res_of = `RES_R7;
            4'h8:    res_of = `RES_R8;
            default: res_of = `RES_R9;
         endcase
      end
   endfunction

   // code times resolution as a double; mantissa truncated, not rounded
   function [63:0] to_real;
      input [11:0] c;
      input [63:0] res;
      reg   [11:0] mag;
      reg   [64:0] prod;
      reg   [64:0] norm;
      reg   [10:0] pos;
      integer      i;
      begin
         mag  = c[11] ? (~c + 12'h001) : c;
         prod = mag * {1'b1, res[51:0]};
         pos  = 11'h000;
         for (i = 0; i < 65; i = i + 1) begin
            if (prod[i]) begin
               pos = i[10:0];
            end
         end
         norm = prod << (11'd64 - pos);
         if (mag == 12'h000) begin
            to_real = 64'h0000000000000000;
         end else begin
            to_real = {c[11], res[62:52] + pos - 11'd52, norm[63:12]};
         end
      end
   endfunction

   reg         rst_meta_reg;
   reg         rst_sync_reg;
   reg  [11:0] mem [0:`MEM_DEPTH-1];
   reg  [8:0]  cnt_reg;
   reg  [8:0]  wr_addr_reg;
   reg  [8:0]  rd_addr_reg;
   reg  [8:0]  left_reg;
   reg         acq_reg;
   reg         busy_reg;
   reg         src_mem_reg;
   reg  [1:0]  fmt_reg;
   reg  [3:0]  label_reg;
   reg  [3:0]  range_reg;
   reg         quest_reg;
   reg  [6:0]  state_reg;
   reg         hdr_reg;
   reg  [63:0] sh_reg;
   reg  [3:0]  sh_cnt_reg;
   reg  [7:0]  out_data_reg;
   reg         out_valid_reg;
   reg         out_eoi_reg;
   reg  [47:0] ascii_s;
   reg  [3:0]  ascii_len;
   reg  [63:0] ascii_word;

   wire        rst_n = rst_sync_reg;
   wire        f_in_valid;
   wire        f_in_ready;
   wire [11:0] f_in_data;
   wire        f_out_valid;
   wire [11:0] f_out_data;
   wire        can_emit = !out_valid_reg || out_ready;
   wire        f_pop = state_reg[3] && f_out_valid && can_emit;
   wire        take = adc_valid && adc_ready;
   wire        mem_feed = busy_reg && src_mem_reg && !acq_reg && (rd_addr_reg != cnt_reg);
   wire        launch = acquisition_launch && !busy_reg;
   wire [8:0]  cnt_lim = (reading_count == 9'h000) ? 9'h001 :
                         (reading_count > `MEM_DEPTH) ? `MEM_DEPTH : reading_count;
   wire [11:0] len_bytes = (fmt_reg == `FMT_PACKED) ? {2'b00, cnt_reg, 1'b0} : {cnt_reg, 3'b000};
   wire [35:0] len_txt = dec_text(len_bytes);
   wire [11:0] code = f_out_data;
   wire [11:0] mag = code[11] ? (~code + 12'h001) : code;
   wire [35:0] rd_txt = dec_text(mag);
   wire [63:0] real_val = to_real(code, res_of(range_reg));

   assign adc_ready = acq_reg && (src_mem_reg || f_in_ready);
   assign f_in_valid = src_mem_reg ? mem_feed : (acq_reg && adc_valid);
   assign f_in_data  = src_mem_reg ? mem[rd_addr_reg[`MEM_AW-1:0]] : adc_code;
   assign questionable_amp_over = quest_reg;
   assign out_valid = out_valid_reg;
   assign out_data  = out_data_reg;
   assign out_eoi   = out_eoi_reg;
   assign busy      = busy_reg;

   reading_fifo #(
      .WIDTH (12),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_pop),
      .out_data  (f_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // reading memory; a new launch simply rewrites from address zero
   always @(posedge ref_clk) begin
      if (take) begin
         mem[wr_addr_reg[`MEM_AW-1:0]] <= adc_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg     <= 9'h001;
         wr_addr_reg <= 9'h000;
         rd_addr_reg <= 9'h000;
         acq_reg     <= 1'b0;
         src_mem_reg <= 1'b0;
         fmt_reg     <= `FMT_ASCII;
         label_reg   <= 4'h0;
         range_reg   <= 4'h0;
         quest_reg   <= 1'b0;
      end else begin
         if (launch) begin
            cnt_reg     <= cnt_lim;
            wr_addr_reg <= 9'h000;
            rd_addr_reg <= 9'h000;
            acq_reg     <= 1'b1;
            src_mem_reg <= local_bus_route ? local_bus_source_select : vme_source_select;
            fmt_reg     <= (format_select == `FMT_PACKED || format_select == `FMT_REAL) ?
                           format_select : `FMT_ASCII;
            label_reg   <= label_assigned ? channel_label : 4'h0;
            range_reg   <= range_select;
         end else if (take) begin
            wr_addr_reg <= wr_addr_reg + 9'h001;
            if (wr_addr_reg == cnt_reg - 9'h001) begin
               acq_reg <= 1'b0;
            end
         end
         if (mem_feed && f_in_ready) begin
            rd_addr_reg <= rd_addr_reg + 9'h001;
         end
         // set wins over clear; only a status bit, nothing queued
         if (take && adc_code == `CODE_OVR_AMP) begin
            quest_reg <= 1'b1;
         end else if (questionable_clear) begin
            quest_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= S_IDLE;
         busy_reg      <= 1'b0;
         hdr_reg       <= 1'b0;
         left_reg      <= 9'h000;
         sh_reg        <= 64'h0000000000000000;
         sh_cnt_reg    <= 4'h0;
         out_data_reg  <= 8'h00;
         out_valid_reg <= 1'b0;
         out_eoi_reg   <= 1'b0;
      end else begin
         if (out_valid_reg && out_ready) begin
            out_valid_reg <= 1'b0;
            out_eoi_reg   <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               if (launch) begin
                  busy_reg  <= 1'b1;
                  left_reg  <= cnt_lim;
                  state_reg <= (format_select == `FMT_PACKED || format_select == `FMT_REAL) ? S_HASH : S_FETCH;
               end
            end
            S_HASH: begin
               if (can_emit) begin
                  out_data_reg  <= `CHR_HASH;
                  out_valid_reg <= 1'b1;
                  state_reg     <= S_NDIG;
               end
            end
            S_NDIG: begin
               if (can_emit) begin
                  out_data_reg  <= `CHR_ZERO + {4'h0, len_txt[35:32]};
                  out_valid_reg <= 1'b1;
                  sh_reg        <= {len_txt[31:0], 32'h00000000};
                  sh_cnt_reg    <= len_txt[35:32];
                  hdr_reg       <= 1'b1;
                  state_reg     <= S_DATA;
               end
            end
            S_FETCH: begin
               if (f_pop) begin
                  left_reg  <= left_reg - 9'h001;
                  hdr_reg   <= 1'b0;
                  state_reg <= S_DATA;
                  if (fmt_reg == `FMT_PACKED) begin
                     // overrange codes pass through unchanged in the top twelve bits
                     sh_reg     <= {code, label_reg, 48'h000000000000};
                     sh_cnt_reg <= `PACKED_BYTES;
                  end else if (fmt_reg == `FMT_REAL) begin
                     if (code == `CODE_OVR_POS) begin
                        sh_reg <= `REAL_OVR_POS;
                     end else if (code == `CODE_OVR_NEG || code == `CODE_OVR_AMP) begin
                        sh_reg <= `REAL_OVR_NEG;
                     end else begin
                        sh_reg <= real_val;
                     end
                     sh_cnt_reg <= `REAL_BYTES;
                  end else begin
                     sh_reg     <= ascii_word;
                     sh_cnt_reg <= ascii_len;
                  end
               end
            end
            S_DATA: begin
               if (can_emit) begin
                  if (sh_cnt_reg != 4'h0) begin
                     out_data_reg  <= sh_reg[63:56];
                     out_valid_reg <= 1'b1;
                     sh_reg        <= {sh_reg[55:0], 8'h00};
                     sh_cnt_reg    <= sh_cnt_reg - 4'h1;
                  end else if (!hdr_reg && left_reg == 9'h000) begin
                     state_reg <= S_LF;
                  end else begin
                     state_reg <= S_FETCH;
                  end
               end
            end
            S_LF: begin
               if (can_emit) begin
                  out_data_reg  <= `CHR_LF;
                  out_valid_reg <= 1'b1;
                  out_eoi_reg   <= 1'b1;
                  busy_reg      <= 1'b0;
                  state_reg     <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // text reading: optional comma, optional sign, digits, all left aligned
   always @* begin
      ascii_s   = {rd_txt[31:0], 16'h0000};
      ascii_len = rd_txt[35:32];
      if (code[11]) begin
         ascii_s   = {`CHR_MINUS, ascii_s[47:8]};
         ascii_len = ascii_len + 4'h1;
      end
      if (left_reg != cnt_reg) begin
         ascii_s   = {`CHR_COMMA, ascii_s[47:8]};
         ascii_len = ascii_len + 4'h1;
      end
      ascii_word = {ascii_s, 16'h0000};
   end
endmodule // reading_output_formatter

//--- test/host_sink.sv
/*
 host-side byte sink for the reading output formatter: takes bytes on valid and ready,
 keeps them in a queue and counts finished blocks. assumes ref_clk and rstn of the dut.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module host_sink (
   input  wire       ref_clk,
   input  wire       rstn,
   input  wire       out_valid,
   input  wire [7:0] out_data,
   input  wire       out_eoi,
   input  wire       slow,
   input  wire       stall,
   output reg        out_ready
);
   logic [7:0] rx[$];
   int         n_blocks = 0;

   // reads only when stall was low the cycle before, so a stall can leave a block half read
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         out_ready <= 1'b0;
      end else begin
         if (out_valid && out_ready) begin
            rx.push_back(out_data);
            if (out_eoi) n_blocks++;
         end
         // slow mode takes every other cycle; stall refuses everything
         out_ready <= stall ? 1'b0 : (slow ? ~out_ready : 1'b1);
      end
   end
endmodule // host_sink

//--- test/reading_output_formatter_checker.sv
/*
 concurrent checks on the ports of reading_output_formatter.
 assumes one clock domain, ref_clk, and reset rstn active low.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module reading_output_formatter_checker (
   input wire        ref_clk,
   input wire        rstn,
   input wire        acquisition_launch,
   input wire        adc_valid,
   input wire        adc_ready,
   input wire [11:0] adc_code,
   input wire        questionable_clear,
   input wire        questionable_amp_over,
   input wire        out_valid,
   input wire        out_ready,
   input wire [7:0]  out_data,
   input wire        out_eoi,
   input wire        busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_eoi_on_lf: assert property (out_eoi |-> out_valid && out_data == 8'h0A)
      else $error("eoi without line feed");
   a_byte_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_eoi))
      else $error("output byte changed before taken");
   a_adc_idle: assert property (!busy |-> !adc_ready)
      else $error("converter accepted outside acquisition");
   a_amp_flag_set: assert property (adc_valid && adc_ready && adc_code == 12'h800 |=> questionable_amp_over)
      else $error("amplifier overrange not flagged");
   a_amp_flag_sticky: assert property (questionable_amp_over && !questionable_clear |=> questionable_amp_over)
      else $error("overrange flag lost");
   a_launch_busy: assert property (acquisition_launch && !busy |=> busy)
      else $error("launch did not start");
   a_idle_only_lf: assert property (out_valid && !busy |-> out_eoi)
      else $error("byte after end of block");
   a_busy_ends_lf: assert property ($fell(busy) |-> out_valid && out_eoi)
      else $error("block ended without line feed");

   c_block_end: cover property (out_eoi && out_ready);
   c_refused: cover property (busy && adc_valid && !adc_ready);
   c_flag_clear: cover property (questionable_amp_over ##1 questionable_clear);
endmodule // reading_output_formatter_checker

bind reading_output_formatter reading_output_formatter_checker i_chk (
   .ref_clk(ref_clk), .rstn(rstn), .acquisition_launch(acquisition_launch), .adc_valid(adc_valid),
   .adc_ready(adc_ready), .adc_code(adc_code), .questionable_clear(questionable_clear),
   .questionable_amp_over(questionable_amp_over), .out_valid(out_valid), .out_ready(out_ready),
   .out_data(out_data), .out_eoi(out_eoi), .busy(busy));

//--- test/reading_output_formatter_tb.sv
/*
 self-checking bench for reading_output_formatter with a host byte sink.
 assumes the dut, host_sink and the bound checker are compiled before it.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module reading_output_formatter_tb;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        acquisition_launch = 1'b0;
   logic [8:0]  reading_count = 9'h000;
   logic [1:0]  format_select = 2'h0;
   logic [3:0]  channel_label = 4'h0;
   logic        label_assigned = 1'b0;
   logic        vme_source_select = 1'b0;
   logic        local_bus_source_select = 1'b0;
   logic        local_bus_route = 1'b0;
   logic [3:0]  range_select = 4'h0;
   logic        adc_valid = 1'b0;
   logic [11:0] adc_code = 12'h000;
   logic        questionable_clear = 1'b0;
   logic        slow = 1'b0;
   logic        stall = 1'b0;
   wire         adc_ready, questionable_amp_over, out_valid, out_ready, out_eoi, busy;
   wire  [7:0]  out_data;
   int          mismatches = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          max_wait;
   logic [11:0] codes[$];
   logic [7:0]  exp[$];

   reading_output_formatter i_dut (
      .ref_clk(ref_clk), .rstn(rstn), .acquisition_launch(acquisition_launch), .reading_count(reading_count),
      .format_select(format_select), .channel_label(channel_label), .label_assigned(label_assigned),
      .vme_source_select(vme_source_select), .local_bus_source_select(local_bus_source_select),
      .local_bus_route(local_bus_route), .range_select(range_select), .adc_valid(adc_valid),
      .adc_ready(adc_ready), .adc_code(adc_code), .questionable_clear(questionable_clear),
      .questionable_amp_over(questionable_amp_over), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_eoi(out_eoi), .busy(busy));

   host_sink i_host (
      .ref_clk(ref_clk), .rstn(rstn), .out_valid(out_valid), .out_data(out_data), .out_eoi(out_eoi),
      .slow(slow), .stall(stall), .out_ready(out_ready));

   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   // ceiling well above the longest scenario, a stalled 20-reading block
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("Error at %0t: run did not finish", $time);
         end_sim;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task launch(input [1:0] fmt, input [8:0] cnt, input [3:0] lab, input lab_en, input vsrc, input lsrc,
               input route, input [3:0] rng);
      @(posedge ref_clk);
      format_select <= fmt;
      reading_count <= cnt;
      channel_label <= lab;
      label_assigned <= lab_en;
      vme_source_select <= vsrc;
      local_bus_source_select <= lsrc;
      local_bus_route <= route;
      range_select <= rng;
      acquisition_launch <= 1'b1;
      @(posedge ref_clk);
      acquisition_launch <= 1'b0;
   endtask

   // code and valid held until the edge where ready is high
   task feed;
      int w;
      max_wait = 0;
      foreach (codes[i]) begin
         adc_valid <= 1'b1;
         adc_code <= codes[i];
         w = 0;
         do begin
            @(negedge ref_clk);
            w++;
         end while (adc_ready !== 1'b1 && w < 5000);
         if (w > max_wait) max_wait = w;
         @(posedge ref_clk);
      end
      adc_valid <= 1'b0;
   endtask

   task push_hdr(input int n);
      string s;
      s = $sformatf("%0d", n);
      exp.push_back(8'h23);
      exp.push_back(8'h30 + s.len());
      foreach (s[i]) exp.push_back(s[i]);
   endtask

   task push_word(input logic [63:0] v, input int nb);
      for (int i = nb - 1; i >= 0; i--) exp.push_back(v[8*i +: 8]);
   endtask

   task check_bytes(input string name, input int nb0);
      int k;
      k = 0;
      while (i_host.n_blocks == nb0 && k < 4000) begin
         @(posedge ref_clk);
         k++;
      end
      repeat (2) @(posedge ref_clk);
      exp.push_back(8'h0A);
      n_tests++;
      if (i_host.rx.size() != exp.size()) begin
         mismatches++;
         $display("Error at %0t: %s got %0d bytes exp %0d", $time, name, i_host.rx.size(), exp.size());
      end else begin
         foreach (exp[i]) if (i_host.rx[i] !== exp[i]) begin
            mismatches++;
            $display("Error at %0t: %s byte %0d got %h exp %h", $time, name, i, i_host.rx[i], exp[i]);
         end
      end
      $display("%s done", name);
      i_host.rx.delete();
      exp.delete();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task t_text;
      string s;
      int nb;
      s = "-5,123,0";
      // second pass uses the unused format code, which must fall back to text
      for (int f = 0; f < 2; f++) begin
         nb = i_host.n_blocks;
         codes = '{12'hFFB, 12'h07B, 12'h000};
         foreach (s[i]) exp.push_back(s[i]);
         launch(f ? 2'h3 : 2'h0, 9'h003, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
         feed;
         check_bytes("text", nb);
      end
   endtask

   task t_packed;
      int nb;
      nb = i_host.n_blocks;
      slow <= 1'b1;
      codes = '{12'h7FF, 12'h802};
      push_hdr(4);
      push_word(64'h7FFA, 2);
      push_word(64'h802A, 2);
      launch(2'h1, 9'h002, 4'hA, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
      feed;
      check_bytes("packed", nb);
      slow <= 1'b0;
   endtask

   task t_memory;
      int nb;
      for (int r = 0; r < 2; r++) begin
         nb = i_host.n_blocks;
         codes.delete();
         push_hdr(12);
         for (int i = 0; i < 6; i++) begin
            codes.push_back(12'h100 * r + i + 1);
            push_word({codes[i], 4'h0}, 2);
         end
         launch(2'h1, 9'h006, 4'h5, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
         feed;
         check_bytes("memory", nb);
      end
   endtask

   task t_real;
      int nb;
      nb = i_host.n_blocks;
      codes = '{12'h001, 12'h7FF, 12'h800};
      push_hdr(24);
      push_word($realtobits(1 * 0.05), 8);
      push_word($realtobits(9.9e37), 8);
      push_word($realtobits(-9.9e37), 8);
      launch(2'h2, 9'h003, 4'h3, 1'b1, 1'b1, 1'b0, 1'b1, 4'h9);
      feed;
      check_bytes("real", nb);
      n_tests++;
      if (questionable_amp_over !== 1'b1) begin
         mismatches++;
         $display("Error at %0t: overrange flag not set", $time);
      end
      questionable_clear <= 1'b1;
      repeat (2) @(posedge ref_clk);
      questionable_clear <= 1'b0;
      n_tests++;
      if (questionable_amp_over !== 1'b0) begin
         mismatches++;
         $display("Error at %0t: overrange flag not cleared", $time);
      end
      $display("flag done");
   endtask

   task t_fill;
      int nb;
      nb = i_host.n_blocks;
      stall <= 1'b1;
      codes.delete();
      push_hdr(40);
      for (int i = 0; i < 20; i++) begin
         codes.push_back(12'h010 + i);
         push_word({codes[i], 4'h0}, 2);
      end
      launch(2'h1, 9'h014, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
      fork
         feed;
         begin
            repeat (60) @(posedge ref_clk);
            acquisition_launch <= 1'b1;
            @(posedge ref_clk);
            acquisition_launch <= 1'b0;
            repeat (60) @(posedge ref_clk);
            stall <= 1'b0;
         end
      join
      n_tests++;
      if (max_wait < 40) begin
         mismatches++;
         $display("Error at %0t: buffer never refused a reading", $time);
      end
      check_bytes("fill", nb);
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_text;
      t_packed;
      t_memory;
      t_real;
      t_fill;
      end_sim;
   end
endmodule // reading_output_formatter_tb
